/* design/evl_event_log_pmbus.sv */
// event log access over the management bus with pin roles and erase sequencing
// Notes on behaviour
// [RQ1] erase command wipes log, output off meanwhile
// [RQ2] output restarts alone after the erase time
// [RQ3] host plans for output outage during erase
// [RQ4] count command returns number of held events
// [RQ5] entry read uses last written selection
// [RQ6] entry read is block read, count 32 first
// [RQ7] record bytes 9-11 hold run time
// [RQ8] bytes 13-14 temperature, 15-16 status word
// [RQ9] bytes 17-18 hold input voltage at off
// [RQ10] bytes 21-22 hold output current at off
// [RQ11] selection 0x30 newest, 0x30+n is n back
// [RQ12] multipurpose pin is power good or on/off
// [RQ13] address pins give high and low digits
// [RQ14] role field 0000 power good, 0010 on/off
// [RQ15] bad selection rejected, invalid data flag set
// [RQ16] check bytes returned as stored
`timescale 1ns/100ps
module evl_event_log_pmbus #(
  parameter int ERASE_CYCLES = evl_pkg::ERASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  input  wire logic [2:0]  address_pin_high,
  input  wire logic [2:0]  address_pin_low,
  input  wire logic        multipurpose_signal_pin_i,
  output logic             multipurpose_signal_pin_o,
  output logic             multipurpose_signal_pin_oe,
  input  wire logic        vout_ok_i,
  output logic             power_enable,
  output logic             erase_busy,
  input  wire logic        log_capture,
  input  wire logic [23:0] log_runtime,
  input  wire logic [15:0] log_temp,
  input  wire logic [15:0] log_status_word,
  input  wire logic [15:0] log_vin,
  input  wire logic [15:0] log_iout,
  input  wire logic [7:0]  log_check
);

  localparam logic [evl_pkg::ERASE_CNT_W-1:0] ERASE_LAST = evl_pkg::ERASE_CNT_W'(ERASE_CYCLES - 1);

  // synchroniser stages: scl, sda, pin, vout ok, six strap bits
  logic [9:0]  sync1_q;
  logic [9:0]  sync2_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic        scl_s;
  logic        sda_s;
  logic        pin_s;
  logic        vok_s;
  logic [6:0]  bus_addr_q;
  logic [6:0]  bus_addr_d;

  evl_pkg::evl_bus_state_t state_q;
  evl_pkg::evl_bus_state_t state_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic [1:0]  byte_num_q;
  logic [1:0]  byte_num_d;
  logic        ack_phase_q;
  logic        ack_phase_d;
  logic        next_tx_q;
  logic        next_tx_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic [5:0]  tx_idx_q;
  logic [5:0]  tx_idx_d;
  logic        sda_oe_q;
  logic        sda_oe_d;
  logic [7:0]  sel_q;
  logic [7:0]  sel_d;
  logic [4:0]  role_q;
  logic [4:0]  role_d;
  logic [7:0]  cml_q;
  logic [7:0]  cml_d;
  logic        erasing_q;
  logic        erasing_d;
  logic [evl_pkg::ERASE_CNT_W-1:0] erase_cnt_q;
  logic [evl_pkg::ERASE_CNT_W-1:0] erase_cnt_d;
  logic [evl_pkg::ERASE_CNT_W-1:0] erase_len_q;
  logic        power_en_q;
  logic        power_en_d;
  logic        mp_o_q;
  logic        mp_o_d;
  logic        mp_oe_q;
  logic        mp_oe_d;
  logic        alert_oe_q;
  logic        alert_oe_d;

  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        byte_done;
  logic        wr_strobe;
  logic        erase_start;
  logic        onoff_ok;
  logic [7:0]  set_mask;
  logic [7:0]  clr_mask;
  logic [7:0]  rec_data;
  logic [7:0]  log_count;
  logic [4:0]  rd_back;
  logic [4:0]  rd_byte;

  // selection value inside the supported window
  function automatic logic sel_in_range(input logic [7:0] v);
    sel_in_range = (v >= evl_pkg::SEL_NEWEST) && (v <= evl_pkg::SEL_OLDEST);
  endfunction

  // byte to send for a read of the given command
  function automatic logic [7:0] tx_byte(input logic [7:0] cmd, input logic [5:0] idx, input logic [7:0] rec,
                                          input logic [7:0] cnt, input logic [7:0] sel, input logic [4:0] role,
                                          input logic [7:0] cml);
    tx_byte = evl_pkg::TX_FILL;
    case (cmd)
      evl_pkg::CMD_COUNT:      tx_byte = (idx == 6'h00) ? cnt : evl_pkg::TX_FILL; // [RQ4]
      evl_pkg::CMD_ENTRY_SEL:  tx_byte = (idx == 6'h00) ? sel : evl_pkg::TX_FILL;
      evl_pkg::CMD_PIN_ROLE:   tx_byte = (idx == 6'h00) ? {3'h0, role} : evl_pkg::TX_FILL;
      evl_pkg::CMD_STATUS_CML: tx_byte = (idx == 6'h00) ? cml : evl_pkg::TX_FILL;
      evl_pkg::CMD_ENTRY_READ: begin
        if (idx == 6'h00) begin
          tx_byte = evl_pkg::BLOCK_COUNT; // [RQ6]
        end else if (idx <= 6'(evl_pkg::BLOCK_COUNT)) begin
          tx_byte = rec; // [RQ5]
        end
      end
      default: tx_byte = evl_pkg::TX_FILL;
    endcase
  endfunction

  // command codes this block answers to
  function automatic logic cmd_known(input logic [7:0] cmd);
    cmd_known = (cmd == evl_pkg::CMD_ERASE) || (cmd == evl_pkg::CMD_COUNT) || (cmd == evl_pkg::CMD_ENTRY_READ) ||
                (cmd == evl_pkg::CMD_ENTRY_SEL) || (cmd == evl_pkg::CMD_STATUS_CML) || (cmd == evl_pkg::CMD_PIN_ROLE);
  endfunction

  // two-stage synchronisers and edge history
  always_comb begin
    bus_addr_d = evl_pkg::ADDR_BASE + {1'b0, sync2_q[5:3], sync2_q[2:0]}; // [RQ13]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q    <= 10'h3ff;
      sync2_q    <= 10'h3ff;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      bus_addr_q <= 7'h00;
    end else begin
      sync1_q    <= {scl_i, sda_i, multipurpose_signal_pin_i, vout_ok_i, address_pin_high, address_pin_low};
      sync2_q    <= sync1_q;
      scl_p_q    <= sync2_q[9];
      sda_p_q    <= sync2_q[8];
      bus_addr_q <= bus_addr_d;
    end
  end

  assign scl_s     = sync2_q[9];
  assign sda_s     = sync2_q[8];
  assign pin_s     = sync2_q[7];
  assign vok_s     = sync2_q[6];
  assign scl_rise  = scl_s && !scl_p_q;
  assign scl_fall  = !scl_s && scl_p_q;
  assign bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign bus_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign byte_done = !bus_start && !bus_stop && (state_q == evl_pkg::ST_RX) && scl_rise && (bit_q == 4'h7);
  assign wr_strobe = byte_done && (byte_num_q == 2'h2);
  assign rd_back   = 5'(sel_q - evl_pkg::SEL_NEWEST); // [RQ11]
  assign rd_byte   = 5'(tx_idx_q - 6'h01);

  // bus engine, command decode, register writes and erase sequencing
  always_comb begin
    state_d     = state_q;
    bit_d       = bit_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    byte_num_d  = byte_num_q;
    ack_phase_d = ack_phase_q;
    next_tx_d   = next_tx_q;
    cmd_d       = cmd_q;
    tx_idx_d    = tx_idx_q;
    sda_oe_d    = sda_oe_q;
    sel_d       = sel_q;
    role_d      = role_q;
    set_mask    = 8'h00;
    clr_mask    = 8'h00;
    erase_start = 1'b0;
    if (bus_start) begin
      state_d    = evl_pkg::ST_RX;
      bit_d      = 4'h0;
      byte_num_d = 2'h0;
      sda_oe_d   = 1'b0;
    end else if (bus_stop) begin
      state_d  = evl_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        evl_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              bit_d       = 4'h0;
              state_d     = evl_pkg::ST_ACK;
              ack_phase_d = 1'b0;
              next_tx_d   = 1'b0;
              if (byte_num_q == 2'h0) begin
                if (shift_d[7:1] == bus_addr_q) begin // [RQ13]
                  next_tx_d = shift_d[0];
                  tx_idx_d  = 6'h00;
                end else begin
                  state_d = evl_pkg::ST_IDLE;
                end
              end else if (byte_num_q == 2'h1) begin
                cmd_d = shift_d;
                if (!cmd_known(shift_d)) begin
                  set_mask[evl_pkg::CML_BAD_CMD_BIT] = 1'b1;
                end
                erase_start = (shift_d == evl_pkg::CMD_ERASE) && !erasing_q; // [RQ1]
              end else begin
                case (cmd_q)
                  evl_pkg::CMD_ENTRY_SEL: begin
                    if (sel_in_range(shift_d)) begin
                      sel_d = shift_d; // [RQ5]
                    end else begin
                      set_mask[evl_pkg::CML_BAD_DATA_BIT] = 1'b1; // [RQ15]
                    end
                  end
                  evl_pkg::CMD_PIN_ROLE:   role_d   = shift_d[4:0]; // [RQ14]
                  evl_pkg::CMD_STATUS_CML: clr_mask = shift_d;
                  default:                 set_mask[evl_pkg::CML_BAD_CMD_BIT] = 1'b1;
                endcase
              end
              if (byte_num_q != 2'h2) begin
                byte_num_d = byte_num_q + 2'h1;
              end
            end
          end
        end
        evl_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (!ack_phase_q) begin
              sda_oe_d    = 1'b1;
              ack_phase_d = 1'b1;
            end else if (next_tx_q) begin
              tx_d     = tx_byte(cmd_q, tx_idx_q, rec_data, log_count, sel_q, role_q, cml_q);
              sda_oe_d = !tx_d[7];
              state_d  = evl_pkg::ST_TX;
            end else begin
              sda_oe_d = 1'b0;
              state_d  = evl_pkg::ST_RX;
            end
          end
        end
        evl_pkg::ST_TX: begin
          if (scl_fall) begin
            tx_d  = {tx_q[6:0], 1'b0};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              bit_d    = 4'h0;
              sda_oe_d = 1'b0;
              state_d  = evl_pkg::ST_TXACK;
              if (tx_idx_q != 6'h3f) begin
                tx_idx_d = tx_idx_q + 6'h01;
              end
            end else begin
              sda_oe_d = !tx_d[7];
            end
          end
        end
        evl_pkg::ST_TXACK: begin
          if (scl_rise) begin
            state_d = sda_s ? evl_pkg::ST_IDLE : evl_pkg::ST_TXLD; // nack ends the read
          end
        end
        evl_pkg::ST_TXLD: begin
          if (scl_fall) begin
            tx_d     = tx_byte(cmd_q, tx_idx_q, rec_data, log_count, sel_q, role_q, cml_q);
            sda_oe_d = !tx_d[7];
            state_d  = evl_pkg::ST_TX;
          end
        end
        evl_pkg::ST_IDLE: state_d = evl_pkg::ST_IDLE;
        default:          state_d = evl_pkg::ST_IDLE;
      endcase
    end
    // fault flags: a new event wins over a clear in the same cycle
    cml_d = (cml_q & ~clr_mask) | set_mask;
    // erase timer holds the output off for the whole erase
    erasing_d   = erasing_q;
    erase_cnt_d = erase_cnt_q;
    if (erase_start) begin
      erasing_d   = 1'b1; // [RQ1]
      erase_cnt_d = '0;
    end else if (erasing_q) begin
      if (erase_cnt_q == ERASE_LAST) begin
        erasing_d = 1'b0; // [RQ2]
      end else begin
        erase_cnt_d = erase_cnt_q + 1'b1;
      end
    end
    // pin role and output control
    onoff_ok   = (role_q[3:0] == evl_pkg::ROLE_SEC_ONOFF) ? pin_s : 1'b1; // [RQ12]
    power_en_d = !erasing_d && onoff_ok; // [RQ1] [RQ2]
    mp_oe_d    = (role_d[3:0] == evl_pkg::ROLE_POWER_GOOD); // [RQ14]
    mp_o_d     = power_en_d && vok_s;
    alert_oe_d = |cml_d;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= evl_pkg::ST_IDLE;
      bit_q       <= 4'h0;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      byte_num_q  <= 2'h0;
      ack_phase_q <= 1'b0;
      next_tx_q   <= 1'b0;
      cmd_q       <= 8'h00;
      tx_idx_q    <= 6'h00;
      sda_oe_q    <= 1'b0;
      sel_q       <= evl_pkg::SEL_RESET;
      role_q      <= evl_pkg::PIN_ROLE_RESET;
      cml_q       <= evl_pkg::CML_RESET;
      erasing_q   <= 1'b0;
      erase_cnt_q <= '0;
      power_en_q  <= 1'b0;
      mp_o_q      <= 1'b0;
      mp_oe_q     <= 1'b1;
      alert_oe_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      bit_q       <= bit_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      byte_num_q  <= byte_num_d;
      ack_phase_q <= ack_phase_d;
      next_tx_q   <= next_tx_d;
      cmd_q       <= cmd_d;
      tx_idx_q    <= tx_idx_d;
      sda_oe_q    <= sda_oe_d;
      sel_q       <= sel_d;
      role_q      <= role_d;
      cml_q       <= cml_d;
      erasing_q   <= erasing_d;
      erase_cnt_q <= erase_cnt_d;
      power_en_q  <= power_en_d;
      mp_o_q      <= mp_o_d;
      mp_oe_q     <= mp_oe_d;
      alert_oe_q  <= alert_oe_d;
    end
  end

  // record store, held empty for the whole erase
  evl_log_store u_store (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clear       (erasing_q),
    .capture     (log_capture),
    .rec_runtime (log_runtime),
    .rec_temp    (log_temp),
    .rec_status  (log_status_word),
    .rec_vin     (log_vin),
    .rec_iout    (log_iout),
    .rec_check   (log_check),
    .rd_back     (rd_back),
    .rd_byte     (rd_byte),
    .rd_data     (rec_data),
    .count       (log_count)
  );

  // open-drain lines only ever pull low
  assign sda_o                      = 1'b0;
  assign sda_oe                     = sda_oe_q;
  assign alert_o                    = 1'b0;
  assign alert_oe                   = alert_oe_q;
  assign multipurpose_signal_pin_o  = mp_o_q;
  assign multipurpose_signal_pin_oe = mp_oe_q;
  assign power_enable               = power_en_q;
  assign erase_busy                 = erasing_q;

  // length of the current erase, read only by the checks below
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_len_q <= '0;
    end else begin
      erase_len_q <= erasing_q ? erase_len_q + 1'b1 : '0;
    end
  end

  chk_erase_power_off: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    erase_start |=> erasing_q && !power_en_q ##1 (log_count == 8'h00))
    else $error("erase did not switch output off and wipe the log");
  chk_erase_length: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    $fell(erasing_q) |-> erase_len_q == ERASE_CYCLES)
    else $error("erase interval has the wrong length");
  chk_erase_restart: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    $fell(erasing_q) && $past(onoff_ok) |-> power_en_q)
    else $error("output not restarted after erase");
  chk_count_reply: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    !bus_start && !bus_stop && state_q == evl_pkg::ST_ACK && scl_fall && ack_phase_q && next_tx_q &&
    cmd_q == evl_pkg::CMD_COUNT |=> tx_q == $past(log_count) && state_q == evl_pkg::ST_TX)
    else $error("count reply does not match held events");
  chk_block_count: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    !bus_start && !bus_stop && state_q == evl_pkg::ST_ACK && scl_fall && ack_phase_q && next_tx_q &&
    cmd_q == evl_pkg::CMD_ENTRY_READ && tx_idx_q == 6'h00 |=> tx_q == evl_pkg::BLOCK_COUNT && sda_oe_q)
    else $error("block read does not open with its byte count");
  chk_sel_accept: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    wr_strobe && cmd_q == evl_pkg::CMD_ENTRY_SEL && sel_in_range(shift_d) |=> sel_q == $past(shift_d))
    else $error("valid selection not stored");
  chk_sel_reject: assert property (@(posedge clk) disable iff (sys_rst) // [RQ15]
    wr_strobe && cmd_q == evl_pkg::CMD_ENTRY_SEL && !sel_in_range(shift_d) |=>
    cml_q[evl_pkg::CML_BAD_DATA_BIT] && sel_q == $past(sel_q) ##1 alert_oe_q)
    else $error("bad selection not rejected and flagged");
  chk_pin_role: assert property (@(posedge clk) disable iff (sys_rst) // [RQ14]
    $changed(role_q) |-> multipurpose_signal_pin_oe == (role_q[3:0] == evl_pkg::ROLE_POWER_GOOD))
    else $error("multipurpose pin direction does not follow its role");
  chk_addr_miss: assert property (@(posedge clk) disable iff (sys_rst) // [RQ13]
    byte_done && byte_num_q == 2'h0 && shift_d[7:1] != bus_addr_q |=> state_q == evl_pkg::ST_IDLE && !sda_oe_q)
    else $error("foreign address was answered");

  cov_erase_done: cover property (@(posedge clk) disable iff (sys_rst) $fell(erasing_q));
  cov_block_read: cover property (@(posedge clk) disable iff (sys_rst)
    cmd_q == evl_pkg::CMD_ENTRY_READ && tx_idx_q == 6'h21 && state_q == evl_pkg::ST_TXACK);
  cov_sel_reject: cover property (@(posedge clk) disable iff (sys_rst)
    wr_strobe && cmd_q == evl_pkg::CMD_ENTRY_SEL && !sel_in_range(shift_d));

endmodule

/* design/evl_pkg.sv */
// constants, field layout and types shared by the event log access logic
package evl_pkg;

  // command codes on the management bus
  localparam logic [7:0] CMD_ERASE      = 8'hd1;
  localparam logic [7:0] CMD_COUNT      = 8'hd2;
  localparam logic [7:0] CMD_ENTRY_READ = 8'hd6;
  localparam logic [7:0] CMD_ENTRY_SEL  = 8'hd7;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
  localparam logic [7:0] CMD_PIN_ROLE   = 8'he0;

  // entry selection values
  localparam logic [7:0] SEL_NEWEST = 8'h30;
  localparam logic [7:0] SEL_OLDEST = 8'h43;
  localparam logic [7:0] SEL_RESET  = 8'h30;

  // block read framing and record geometry
  localparam logic [7:0] BLOCK_COUNT = 8'h20;
  localparam logic [4:0] LOG_DEPTH   = 5'h14;
  localparam logic [9:0] REC_BYTES   = 10'h020;
  localparam int         MEM_WORDS   = 640;
  localparam logic [7:0] TX_FILL     = 8'hff;

  // byte positions inside a stored record (record byte n sits at n-1)
  localparam logic [4:0] RUNTIME_POS = 5'h08;
  localparam logic [4:0] TEMP_POS    = 5'h0c;
  localparam logic [4:0] STATUS_POS  = 5'h0e;
  localparam logic [4:0] VIN_POS     = 5'h10;
  localparam logic [4:0] IOUT_POS    = 5'h14;

  // communication fault status layout
  localparam int         CML_BAD_CMD_BIT  = 7;
  localparam int         CML_BAD_DATA_BIT = 6;
  localparam logic [7:0] CML_RESET        = 8'h00;

  // pin role configuration
  localparam logic [4:0] PIN_ROLE_RESET  = 5'h00;
  localparam logic [3:0] ROLE_POWER_GOOD = 4'h0;
  localparam logic [3:0] ROLE_SEC_ONOFF  = 4'h2;

  // bus address base, strap digits are added to it (value is arbitrary)
  localparam logic [6:0] ADDR_BASE = 7'h40;

  // erase timing
  localparam int ERASE_TIME_MS = 400;
  localparam int CLK_FREQ_HZ   = 125000000;
  localparam int ERASE_CYCLES  = ERASE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int ERASE_CNT_W   = 26;

  // bus engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_TXLD
  } evl_bus_state_t;

endpackage

/* design/evl_log_store.sv */
// event record ring store with capture, wipe and indexed byte read
`timescale 1ns/100ps
module evl_log_store (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clear,
  input  wire logic        capture,
  input  wire logic [23:0] rec_runtime,
  input  wire logic [15:0] rec_temp,
  input  wire logic [15:0] rec_status,
  input  wire logic [15:0] rec_vin,
  input  wire logic [15:0] rec_iout,
  input  wire logic [7:0]  rec_check,
  input  wire logic [4:0]  rd_back,
  input  wire logic [4:0]  rd_byte,
  output logic      [7:0]  rd_data,
  output logic      [7:0]  count
);

  logic [7:0] mem [0:evl_pkg::MEM_WORDS-1];
  logic [7:0] rec_b [0:31];
  logic [4:0] wptr_q;
  logic [4:0] wptr_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [5:0] slot_sum;
  logic [4:0] slot;
  logic [9:0] wr_base;
  logic [9:0] rd_idx;

  // assemble the record, little-endian fields, check bytes kept as given
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      rec_b[i] = rec_check; // [RQ16]
    end
    rec_b[evl_pkg::RUNTIME_POS]        = rec_runtime[7:0]; // [RQ7]
    rec_b[evl_pkg::RUNTIME_POS + 5'h1] = rec_runtime[15:8];
    rec_b[evl_pkg::RUNTIME_POS + 5'h2] = rec_runtime[23:16];
    rec_b[evl_pkg::TEMP_POS]           = rec_temp[7:0]; // [RQ8]
    rec_b[evl_pkg::TEMP_POS + 5'h1]    = rec_temp[15:8];
    rec_b[evl_pkg::STATUS_POS]         = rec_status[7:0]; // [RQ8]
    rec_b[evl_pkg::STATUS_POS + 5'h1]  = rec_status[15:8];
    rec_b[evl_pkg::VIN_POS]            = rec_vin[7:0]; // [RQ9]
    rec_b[evl_pkg::VIN_POS + 5'h1]     = rec_vin[15:8];
    rec_b[evl_pkg::IOUT_POS]           = rec_iout[7:0]; // [RQ10]
    rec_b[evl_pkg::IOUT_POS + 5'h1]    = rec_iout[15:8];
  end

  // write pointer and held count, wipe wins over capture
  always_comb begin
    wptr_d  = wptr_q;
    count_d = count_q;
    if (clear) begin
      wptr_d  = 5'h00; // [RQ1]
      count_d = 8'h00;
    end else if (capture) begin
      wptr_d = (wptr_q == evl_pkg::LOG_DEPTH - 5'h1) ? 5'h00 : wptr_q + 5'h1;
      if (count_q != {3'h0, evl_pkg::LOG_DEPTH}) begin
        count_d = count_q + 8'h01; // [RQ4]
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_q  <= 5'h00;
      count_q <= 8'h00;
    end else begin
      wptr_q  <= wptr_d;
      count_q <= count_d;
    end
  end

  assign wr_base = 10'(wptr_q) * evl_pkg::REC_BYTES;

  // record storage, no reset; reads are not checked against the count, so stale slots read back as left
  always_ff @(posedge clk) begin
    if (capture && !clear) begin
      for (int i = 0; i < 32; i++) begin
        mem[wr_base + 10'(i)] <= rec_b[i];
      end
    end
  end

  // slot n places back from the newest one
  assign slot_sum = 6'(wptr_q) + 6'(evl_pkg::LOG_DEPTH) - 6'h01 - 6'(rd_back);
  assign slot     = (slot_sum >= 6'(evl_pkg::LOG_DEPTH)) ? 5'(slot_sum - 6'(evl_pkg::LOG_DEPTH)) : slot_sum[4:0];
  assign rd_idx   = 10'(slot) * evl_pkg::REC_BYTES + 10'(rd_byte);
  assign rd_data  = mem[rd_idx]; // [RQ11]
  assign count    = count_q;

  chk_runtime_stored: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    capture && !clear |=> mem[$past(wr_base) + 10'(evl_pkg::RUNTIME_POS)] == $past(rec_runtime[7:0]))
    else $error("runtime byte not stored at its record position");

endmodule

/* testbench/evl_host.sv */
// bus host model: driven clock and open-drain data with byte, write and block-read tasks
`timescale 1ns/100ps
module evl_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_dn
);
  logic [7:0] rx [0:32];
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // five system clocks per step, used for start and stop framing
  task automatic st(input logic c, input logic d);
    repeat (5) @(posedge clk);
    scl <= c;
    sda_dn <= ~d;
  endtask
  // ten system clocks per bit: data set while clock low, sampled at the end of clock high
  task automatic bit_io(input logic d, output logic r);
    repeat (2) @(posedge clk);
    sda_dn <= ~d;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (5) @(posedge clk);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic go();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask
  task automatic halt();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // write with optional data byte; the data byte is sent only when nd is set
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic nd, output logic ack);
    logic r;
    go();
    put({a, 1'b0}, ack);
    put(c, r);
    if (nd) put(d, r);
    halt();
  endtask
  // block read: count byte first, last byte refused to end the transfer
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, output logic ack);
    logic r;
    go();
    put({a, 1'b0}, ack);
    put(c, r);
    go();
    put({a, 1'b1}, r);
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rx[j][i]);
      bit_io(j == n - 1, r);
    end
    halt();
  endtask
endmodule

/* testbench/event_log_pmbus_access_test.sv */
// self-checking bench for the event log access block
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", n, e, a); end end
module event_log_pmbus_access_test;
  localparam logic [6:0] A = evl_pkg::ADDR_BASE + 7'h15;
  logic clk = 1'b0, sys_rst = 1'b1, cap = 1'b0, vok = 1'b1, pin_i = 1'b1, ack;
  logic [23:0] rt = 24'h0;
  logic [15:0] tp = 16'h0, sw = 16'h0, vi = 16'h0, io = 16'h0;
  logic [7:0] ck = 8'h0;
  int n_fail = 0, samples_checked = 0, cyc = 0, busy_n = 0;
  wire scl, sda_dn, sda_oe, pin_o, pin_oe, pwr, busy, alrt;
  wire sda = ~(sda_dn | sda_oe);
  evl_host h (.clk(clk), .sda(sda), .scl(scl), .sda_dn(sda_dn));
  evl_event_log_pmbus #(.ERASE_CYCLES(200)) DUT (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .alert_o(), .alert_oe(alrt), .address_pin_high(3'h2), .address_pin_low(3'h5),
    .multipurpose_signal_pin_i(pin_i), .multipurpose_signal_pin_o(pin_o), .multipurpose_signal_pin_oe(pin_oe),
    .vout_ok_i(vok), .power_enable(pwr), .erase_busy(busy), .log_capture(cap), .log_runtime(rt),
    .log_temp(tp), .log_status_word(sw), .log_vin(vi), .log_iout(io), .log_check(ck));
  always #4 clk = ~clk;
  // erase length and hang guard
  always @(posedge clk) begin
    cyc++;
    if (busy) busy_n++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic capture(input logic [7:0] k);
    @(posedge clk);
    cap <= 1'b1;
    rt <= 24'h123456 ^ {3{k}};
    {tp, sw, vi, io, ck} <= {16'h7a00 + k, 16'hb100 + k, 16'hc200 + k, 16'hd300 + k, 8'he0 + k};
    @(posedge clk);
    cap <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    h.rd(A, evl_pkg::CMD_COUNT, 1, ack);
    `CHK("addr ack", 1'b1, ack)
    `CHK("empty count", 8'h00, h.rx[0])
    for (int k = 1; k <= 3; k++) capture(k[7:0]);
    h.rd(A, evl_pkg::CMD_COUNT, 1, ack);
    `CHK("count", 8'h03, h.rx[0])
    h.wr(A, evl_pkg::CMD_ENTRY_SEL, 8'h31, 1'b1, ack);
    h.rd(A, evl_pkg::CMD_ENTRY_READ, 33, ack);
    `CHK("byte count", 8'h20, h.rx[0])
    `CHK("runtime", 24'h123456 ^ {3{8'h02}}, {h.rx[11], h.rx[10], h.rx[9]})
    `CHK("temp status", {16'hb102, 16'h7a02}, {h.rx[16], h.rx[15], h.rx[14], h.rx[13]})
    `CHK("vin", 16'hc202, {h.rx[18], h.rx[17]})
    `CHK("iout", 16'hd302, {h.rx[22], h.rx[21]})
    `CHK("check byte", 8'he2, h.rx[1])
    $display("test entry read done");
    h.wr(A, evl_pkg::CMD_ENTRY_SEL, 8'h44, 1'b1, ack);
    h.rd(A, evl_pkg::CMD_ENTRY_SEL, 1, ack);
    `CHK("selection kept", 8'h31, h.rx[0])
    h.rd(A, evl_pkg::CMD_STATUS_CML, 1, ack);
    `CHK("bad data flag", 1'b1, h.rx[0][6])
    `CHK("alert set", 1'b1, alrt)
    h.wr(A, evl_pkg::CMD_STATUS_CML, 8'hff, 1'b1, ack);
    `CHK("alert cleared", 1'b0, alrt)
    h.wr(7'h6a, evl_pkg::CMD_ENTRY_SEL, 8'h30, 1'b1, ack);
    `CHK("foreign addr ack", 1'b0, ack)
    $display("test selection done");
    `CHK("pin drives", 1'b1, pin_oe)
    `CHK("power good", 1'b1, pin_o)
    vok <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("power not good", 1'b0, pin_o)
    h.wr(A, evl_pkg::CMD_PIN_ROLE, 8'h02, 1'b1, ack);
    pin_i <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("pin released", 1'b0, pin_oe)
    `CHK("remote off", 1'b0, pwr)
    pin_i <= 1'b1;
    vok <= 1'b1;
    h.wr(A, evl_pkg::CMD_PIN_ROLE, 8'h00, 1'b1, ack);
    $display("test pin role done");
    busy_n = 0;
    h.wr(A, evl_pkg::CMD_ERASE, 8'h00, 1'b0, ack);
    `CHK("erasing", 2'b10, {busy, pwr})
    capture(8'h09);
    for (int i = 0; i < 400 && busy; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK("erase length", 200, busy_n)
    `CHK("power back", 1'b1, pwr)
    h.rd(A, evl_pkg::CMD_COUNT, 1, ack);
    `CHK("wiped count", 8'h00, h.rx[0])
    $display("test erase done");
    tally_and_finish();
  end
endmodule
